// ---- core/cfg_slave_pkg.sv ----
// shared constants and carriers for the serial configuration slave
package cfg_slave_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h69;
    localparam int BYTE_BITS = 8;
    localparam int CFG_BYTES = 3;
    localparam int CFG_BITS = CFG_BYTES * BYTE_BITS;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] HDR_LAST = 2'h2;
    localparam logic [CFG_BITS-1:0] CFG_RESET = 24'h000000;
    localparam logic [7:0] MASK_B0 = 8'h0f;
    localparam logic [7:0] MASK_B1 = 8'hf0;
    localparam logic [7:0] MASK_B2 = 8'hc0;
    localparam int CLOCK_MHZ = 40;
    localparam int HOLD_MAX_MS = 10;
    localparam int HOLD_MAX_CYC = HOLD_MAX_MS * 1000 * CLOCK_MHZ;

    typedef struct packed {
        logic sclIn;
        logic sdaIn;
    } bus_in_s;

    typedef struct packed {
        logic sdaOut;
        logic sdaOe;
        logic sclOut;
        logic sclOe;
    } bus_out_s;

    typedef enum logic [2:0] {
        LinkIdle, LinkAddr, LinkAddrAck, LinkByte, LinkByteAck, LinkSkip
    } link_e;
endpackage : cfg_slave_pkg

// ---- core/level_sync.sv ----
// two flip-flop synchroniser for a single level
`timescale 1ns/10ps
module level_sync (
    input wire logic clock,
    input wire logic resetn,
    input wire logic async,
    output logic synced
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_s;
    sync_s state;
    sync_s next_state;

    always_comb begin
        next_state.first = async;
        next_state.second = state.first;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign synced = state.second;
endmodule : level_sync

// ---- core/smbus_block_write_config_slave.sv ----
// serial block-write configuration slave for a clock fanout buffer
// What this block does
// - answers only address 1101001
// - direction bit zero means write
// - slave receiver only, never transmits
// - works at 100 kbit/s serial rate
// - bytes stored ascending from byte zero
// - count excludes command and count bytes
// - acknowledge every accepted byte
// - transfer valid after count byte acknowledged
// - command and count ignored, data stored
// - surplus data bytes are discarded
// - never holds clock low, no stretching
// - general call is not answered
// - power down floats data pin, keeps config
// - N data bytes load bytes zero to N-1, up to three
// - every byte is eight bits
// - bits taken most significant first
// - one enables output only in bits set in MASK_B0..MASK_B2, zero holds low
`timescale 1ns/10ps
module smbus_block_write_config_slave
    import cfg_slave_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic serialClock,
    input wire logic serial_clock_line,
    input wire logic serial_data_line,
    input wire logic power_down_mode_n,
    input wire logic [cfg_slave_pkg::CFG_BITS-1:0] bufClocks,
    output cfg_slave_pkg::bus_out_s busOut,
    output logic [cfg_slave_pkg::CFG_BITS-1:0] bufOut,
    output logic [cfg_slave_pkg::CFG_BITS-1:0] outEnable,
    output logic transferValid
);
    import cfg_slave_pkg::*;
    localparam int HOLD_W = $clog2(HOLD_MAX_CYC + 1);

    // link side state, clocked by serialClock (fast sampler of the pins)
    typedef struct packed {
        bus_in_s prev;
        link_e phase;
        logic [2:0] bitCnt;
        logic [7:0] shift;
        logic [1:0] hdrCnt;
        logic [1:0] dataIdx;
        logic dataOk;
        logic [CFG_BITS-1:0] cfg;
        logic cfgToggle;
        logic validToggle;
        logic sdaOe;
        logic sclSeen;
    } link_s;

    typedef struct packed {
        logic [CFG_BITS-1:0] cfgCopy;
        logic lastToggle;
        logic lastValid;
        logic valid;
        logic [CFG_BITS-1:0] enable;
        logic [CFG_BITS-1:0] outs;
        logic [HOLD_W-1:0] holdCnt;
        bus_out_s bus;
    } core_s;

    logic sclS;
    logic sdaS;
    logic pdS;
    logic cfgTogS;
    logic valTogS;
    link_s link;
    link_s next_link;
    core_s core;
    core_s next_core;
    bus_in_s now;
    logic ackS;
    logic [CFG_BITS-1:0] bufS;
    logic sclRise;
    logic sclFall;

    level_sync u_sync_scl (
        .clock(serialClock), .resetn(resetn),
        .async(serial_clock_line), .synced(sclS)
    );
    level_sync u_sync_sda (
        .clock(serialClock), .resetn(resetn),
        .async(serial_data_line), .synced(sdaS)
    );
    level_sync u_sync_pd (
        .clock(clock), .resetn(resetn),
        .async(power_down_mode_n), .synced(pdS)
    );
    level_sync u_sync_cfg (
        .clock(clock), .resetn(resetn),
        .async(link.cfgToggle), .synced(cfgTogS)
    );
    level_sync u_sync_val (
        .clock(clock), .resetn(resetn),
        .async(link.validToggle), .synced(valTogS)
    );

    // the ack request crosses into the core clock before it reaches the pin
    level_sync u_sync_ack (
        .clock(clock), .resetn(resetn),
        .async(link.sdaOe), .synced(ackS)
    );

    // each buffered clock input is a pin, so it is synchronised per bit
    for (genvar i = 0; i < CFG_BITS; i++) begin : g_buf_sync
        level_sync u_sync_buf (
            .clock(clock), .resetn(resetn),
            .async(bufClocks[i]), .synced(bufS[i])
        );
    end

    assign now.sclIn = sclS;
    assign now.sdaIn = sdaS;

    assign sclRise = !link.prev.sclIn && now.sclIn;
    assign sclFall = link.prev.sclIn && !now.sclIn;

    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic [7:0] got;
        rise = 1'b0;
        fall = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        got = '0;
        next_link = link;
        next_link.prev = now;
        rise = !link.prev.sclIn && now.sclIn;
        fall = link.prev.sclIn && !now.sclIn;
        start = link.prev.sclIn && now.sclIn
            && link.prev.sdaIn && !now.sdaIn;
        stop = link.prev.sclIn && now.sclIn
            && !link.prev.sdaIn && now.sdaIn;
        got = {link.shift[6:0], now.sdaIn};
        if (stop) begin
            next_link.phase = LinkIdle;
            next_link.sdaOe = 1'b0;
        end else if (start) begin
            next_link.phase = LinkAddr;
            next_link.bitCnt = '0;
            next_link.sdaOe = 1'b0;
            next_link.hdrCnt = '0;
            next_link.dataIdx = '0;
        end else begin
            unique case (link.phase)
                LinkIdle: begin
                    next_link.sdaOe = 1'b0;
                end
                LinkAddr: begin
                    if (rise) begin
                        next_link.shift = got;
                        next_link.bitCnt = link.bitCnt + 3'h1;
                        if (link.bitCnt == BIT_LAST) begin
                            if (got == {DEV_ADDR, 1'b0}) begin
                                next_link.phase = LinkAddrAck;
                            end else begin
                                next_link.phase = LinkIdle;
                            end
                        end
                    end
                end
                LinkAddrAck, LinkByteAck: begin
                    if (fall && !link.sdaOe) begin
                        next_link.sdaOe = 1'b1;
                        next_link.sclSeen = 1'b0;
                    end else if (fall && link.sdaOe && link.sclSeen) begin
                        next_link.sdaOe = 1'b0;
                        next_link.phase = LinkByte;
                        next_link.bitCnt = '0;
                    end else if (rise && link.sdaOe) begin
                        next_link.sclSeen = 1'b1;
                        if (link.phase == LinkByteAck
                            && link.hdrCnt == HDR_LAST
                            && link.dataIdx == '0
                            && !link.dataOk) begin
                            next_link.validToggle = !link.validToggle;
                            next_link.dataOk = 1'b1;
                        end
                    end
                end
                LinkByte: begin
                    if (rise) begin
                        next_link.shift = got;
                        next_link.bitCnt = link.bitCnt + 3'h1;
                        if (link.bitCnt == BIT_LAST) begin
                            next_link.phase = LinkByteAck;
                            if (link.hdrCnt != HDR_LAST) begin
                                next_link.hdrCnt = link.hdrCnt + 2'h1;
                                next_link.dataOk = 1'b0;
                            end else if (link.dataIdx < 2'(CFG_BYTES)) begin
                                next_link.cfg[link.dataIdx*BYTE_BITS
                                    +: BYTE_BITS] = got;
                                next_link.dataIdx = link.dataIdx + 2'h1;
                                next_link.cfgToggle = !link.cfgToggle;
                            end
                        end
                    end
                end
                LinkSkip: begin
                    next_link.phase = LinkIdle;
                end
                default: begin
                    next_link.phase = LinkIdle;
                end
            endcase
        end
    end

    always_ff @(posedge serialClock or negedge resetn) begin
        if (!resetn) begin
            link <= '{prev: '{1'b1, 1'b1}, phase: LinkIdle,
                cfg: CFG_RESET, default: '0};
        end else begin
            link <= next_link;
        end
    end

    // core side: take config when toggle settles
    always_comb begin
        next_core = core;
        next_core.lastToggle = cfgTogS;
        next_core.lastValid = valTogS;
        if (cfgTogS != core.lastToggle) begin
            next_core.cfgCopy = link.cfg;
        end
        next_core.valid = (valTogS != core.lastValid);
        next_core.enable = core.cfgCopy
            & {MASK_B2, MASK_B1, MASK_B0};
        // gate with the enable loaded at this same edge: no stale pulse
        next_core.outs = bufS & next_core.enable;
        // ack watchdog keeps the data line from being held too long
        if (!ackS) begin
            next_core.holdCnt = '0;
        end else if (core.holdCnt != HOLD_W'(HOLD_MAX_CYC)) begin
            next_core.holdCnt = core.holdCnt + 1'b1;
        end
        // only ever pulls data low for an ack, never the clock
        next_core.bus.sdaOut = 1'b0;
        next_core.bus.sclOut = 1'b0;
        next_core.bus.sclOe = 1'b0;
        next_core.bus.sdaOe = ackS && pdS
            && (core.holdCnt != HOLD_W'(HOLD_MAX_CYC));
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            core <= '{cfgCopy: CFG_RESET, default: '0};
        end else begin
            core <= next_core;
        end
    end

    assign busOut = core.bus;
    assign bufOut = core.outs;
    assign outEnable = core.enable;
    assign transferValid = core.valid;

    a_clock_never_driven: assert property (@(posedge clock)
        disable iff (!resetn) !busOut.sclOe)
        else $error("serial clock driven");
    a_pd_floats_data: assert property (@(posedge clock)
        disable iff (!resetn) !$past(pdS) |-> !busOut.sdaOe)
        else $error("data driven in power down");
    a_disabled_low: assert property (@(posedge clock)
        disable iff (!resetn) (bufOut & ~outEnable) == '0)
        else $error("disabled output switching");
    a_reserved_off: assert property (@(posedge clock)
        disable iff (!resetn)
        (outEnable & ~{MASK_B2, MASK_B1, MASK_B0}) == '0)
        else $error("unused output enabled");
    a_ack_low: assert property (@(posedge clock)
        disable iff (!resetn) busOut.sdaOe |-> !busOut.sdaOut)
        else $error("ack not low");
    a_valid_pulse: assert property (@(posedge clock)
        disable iff (!resetn) transferValid |=> !transferValid)
        else $error("valid longer than a cycle");
    a_bad_addr_idle: assert property (@(posedge serialClock)
        disable iff (!resetn)
        (link.phase == LinkAddr && link.bitCnt == BIT_LAST
        && !link.prev.sclIn && now.sclIn
        && {link.shift[6:0], now.sdaIn} != {DEV_ADDR, 1'b0})
        |=> link.phase == LinkIdle)
        else $error("foreign address accepted");
    a_store_order: assert property (@(posedge serialClock)
        disable iff (!resetn)
        $changed(link.cfgToggle) |-> $past(link.hdrCnt) == HDR_LAST)
        else $error("header stored as data");

    // a byte has ended on a falling bus clock and the ack is still owed
    sequence s_ack_due;
        (link.phase == LinkAddrAck || link.phase == LinkByteAck)
            && !link.sdaOe && sclFall;
    endsequence

    // the ack has stood through a high bus clock and that clock now falls
    sequence s_ack_done;
        (link.phase == LinkAddrAck || link.phase == LinkByteAck)
            && link.sdaOe && link.sclSeen && sclFall;
    endsequence

    a_ack_driven: assert property (@(posedge serialClock)
        disable iff (!resetn) s_ack_due |=> link.sdaOe)
        else $error("byte not acknowledged");
    a_ack_released: assert property (@(posedge serialClock)
        disable iff (!resetn)
        s_ack_done |=> !link.sdaOe && link.phase == LinkByte)
        else $error("ack held past its clock");
    a_msb_first: assert property (@(posedge serialClock)
        disable iff (!resetn)
        link.phase == LinkByte && sclRise
        |=> link.shift == {$past(link.shift[6:0]), $past(now.sdaIn)})
        else $error("bit order broken");
    a_idle_keeps_cfg: assert property (@(posedge serialClock)
        disable iff (!resetn)
        link.phase == LinkIdle |=> $stable(link.cfg))
        else $error("config changed while idle");
    a_valid_after_count: assert property (@(posedge serialClock)
        disable iff (!resetn)
        $changed(link.validToggle) |-> $past(link.hdrCnt) == HDR_LAST
        && $past(link.dataIdx) == '0)
        else $error("valid without count ack");
    a_surplus_dropped: assert property (@(posedge serialClock)
        disable iff (!resetn)
        link.dataIdx == 2'(CFG_BYTES) |=> $stable(link.cfg))
        else $error("surplus byte stored");
    a_hold_counted: assert property (@(posedge clock)
        disable iff (!resetn) busOut.sdaOe |-> core.holdCnt != '0)
        else $error("ack hold not timed");
    a_hold_limit: assert property (@(posedge clock)
        disable iff (!resetn)
        core.holdCnt == HOLD_W'(HOLD_MAX_CYC) |=> !busOut.sdaOe)
        else $error("data line held too long");
endmodule : smbus_block_write_config_slave

// ---- test/smbus_host_model.sv ----
// behavioural serial bus host driving block writes
`timescale 1ns/10ps
module smbus_host_model #(
    parameter int HALF = 200
) (
    input wire logic clock,
    input wire logic devSdaLow,
    input wire logic devSclLow,
    output logic sclLine,
    output logic sdaLine
);
    logic hostScl = 1'b1;
    logic hostSda = 1'b1;
    // open-drain wires with pull-ups
    assign sclLine = hostScl & ~devSclLow;
    assign sdaLine = hostSda & ~devSdaLow;
    task automatic half_bit();
        repeat (HALF) @(negedge clock);
    endtask : half_bit
    task automatic start();
        hostSda = 1'b1;
        half_bit();
        hostScl = 1'b1;
        half_bit();
        hostSda = 1'b0;
        half_bit();
        hostScl = 1'b0;
    endtask : start
    task automatic stop();
        hostSda = 1'b0;
        half_bit();
        hostScl = 1'b1;
        half_bit();
        hostSda = 1'b1;
        half_bit();
    endtask : stop
    // eight bits msb first, then a released ack slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            hostSda = b[i];
            half_bit();
            hostScl = 1'b1;
            half_bit();
            hostScl = 1'b0;
        end
        hostSda = 1'b1;
        half_bit();
        hostScl = 1'b1;
        repeat (HALF / 2) @(negedge clock);
        ack = ~sdaLine;
        repeat (HALF / 2) @(negedge clock);
        hostScl = 1'b0;
    endtask : send_byte
    // address, zero command, count, data bytes ascending
    task automatic block_write(input logic [7:0] addrByte, input int n,
            input logic [31:0] data, output logic [7:0] acks);
        logic ack;
        acks = 8'h00;
        start();
        send_byte(addrByte, ack);
        acks[0] = ack;
        if (ack) begin
            send_byte(8'h00, ack);
            acks[1] = ack;
            send_byte(8'(n), ack);
            acks[2] = ack;
            for (int i = 0; i < n; i++) begin
                send_byte(data[31 - 8 * i -: 8], ack);
                acks[3 + i] = ack;
            end
        end
        stop();
    endtask : block_write
endmodule : smbus_host_model

// ---- test/smbus_block_write_config_slave_test.sv ----
// self-checking bench for the serial configuration slave
`timescale 1ns/10ps
module smbus_block_write_config_slave_test;
    import cfg_slave_pkg::*;
    logic clock = 1'b0;
    logic serialClock = 1'b0;
    logic resetn = 1'b0;
    logic power_down_mode_n = 1'b1;
    logic [CFG_BITS-1:0] bufClocks = 24'hffffff;
    bus_out_s busOut;
    logic [CFG_BITS-1:0] bufOut;
    logic [CFG_BITS-1:0] outEnable;
    logic transferValid;
    logic sclLine;
    logic sdaLine;
    logic [7:0] acks;
    logic [CFG_BITS-1:0] cfg = 24'h000000;
    int errorCnt = 0;
    int cmpCount = 0;
    int pulses = 0;
    int cycles = 0;
    always #12.5 clock = ~clock;
    always #32 serialClock = ~serialClock;
    smbus_block_write_config_slave DUT (.clock(clock), .resetn(resetn),
        .serialClock(serialClock), .serial_clock_line(sclLine),
        .serial_data_line(sdaLine), .power_down_mode_n(power_down_mode_n),
        .bufClocks(bufClocks), .busOut(busOut), .bufOut(bufOut),
        .outEnable(outEnable), .transferValid(transferValid));
    smbus_host_model HOST (.clock(clock), .devSdaLow(busOut.sdaOe),
        .devSclLow(busOut.sclOe), .sclLine(sclLine), .sdaLine(sdaLine));
    always @(posedge clock) begin
        cycles++;
        if (transferValid === 1'b1) begin
            pulses++;
        end
        if (cycles == 80000) begin
            errorCnt++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmpCount++;
        if (seen !== want) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // stored config and gated clocks after a transfer
    task automatic check_outputs();
        repeat (20) @(negedge clock);
        check(outEnable, cfg & {MASK_B2, MASK_B1, MASK_B0});
        check(bufOut, cfg & {MASK_B2, MASK_B1, MASK_B0});
        check({busOut.sdaOut, busOut.sclOut, busOut.sclOe}, 3'h0);
        bufClocks = 24'h000000;
        repeat (8) @(negedge clock);
        check(bufOut, 24'h000000);
        bufClocks = 24'hffffff;
        repeat (8) @(negedge clock);
        check(bufOut, cfg & {MASK_B2, MASK_B1, MASK_B0});
    endtask : check_outputs
    task automatic full_write();
        pulses = 0;
        HOST.block_write(8'hd2, 4, 32'ha53cff77, acks);
        cfg = 24'hff3ca5;
        check(acks, 8'h7f);
        check(pulses, 1);
        check_outputs();
    endtask : full_write
    task automatic short_write();
        pulses = 0;
        HOST.block_write(8'hd2, 1, 32'h5a000000, acks);
        cfg[7:0] = 8'h5a;
        check(acks, 8'h0f);
        check(pulses, 1);
        check_outputs();
    endtask : short_write
    // wrong address, read request, general call
    task automatic refused();
        logic [7:0] addrs [3];
        addrs = '{8'hd0, 8'hd3, 8'h00};
        foreach (addrs[i]) begin
            pulses = 0;
            HOST.block_write(addrs[i], 2, 32'h00000000, acks);
            check(acks, 8'h00);
            check(pulses, 0);
            check_outputs();
        end
    endtask : refused
    task automatic power_down();
        power_down_mode_n = 1'b0;
        HOST.block_write(8'hd2, 1, 32'h5a000000, acks);
        check(acks, 8'h00);
        power_down_mode_n = 1'b1;
        check_outputs();
    endtask : power_down
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        repeat (8) @(negedge clock);
        check(outEnable, 24'h000000);
        full_write();
        short_write();
        refused();
        power_down();
        tally_and_finish();
    end
endmodule : smbus_block_write_config_slave_test
